// ===== dsa_consts.svh
// Constants of the data space access unit
//------------------------------------------------------------------------------
// What this block does
// - Lower half decodes to on-chip memory
// - Upper half is paged extended data window
// - Data RAM spans 0800h to 7FFFh
// - Even byte low, odd byte high
// - Post-increment steps one for byte, two word
// - Byte read selects byte onto low lane
// - Shared word decode, separate byte write strobes
// - Odd word access raises address error
// - Misaligned read completes, misaligned write suppressed
// - Byte load keeps working register high byte
// - Sign extend eight bits to sixteen
// - Upper clear zeroes working register high byte
// - Direct thirteen-bit field reaches 0000h-1FFFh
// - Sixteen-bit direct field reaches whole space
// - First two Kbytes hold special function registers
// - Unimplemented register addresses read as zero
// - Separate read and write address generators
//------------------------------------------------------------------------------
`ifndef DSA_CONSTS_SVH
`define DSA_CONSTS_SVH

// Data space map
`define DSA_RAM_BASE      16'h0800
`define DSA_NEAR_MASK     16'h1FFF
`define DSA_RAM_WORDS     15360
`define DSA_RAM_WORD_OFS  14'h0400
`define DSA_BYTE_STEP     16'h0001
`define DSA_WORD_STEP     16'h0002

// Register indexes, byte address is four times the index
`define DSA_IDX_RPAG      8'h32
`define DSA_IDX_WPAG      8'h34
`define DSA_IDX_STAT      8'h38
`define DSA_IDX_MASK      8'h3A

// Page selects seen by the core inside the register area
`define DSA_CORE_RPAG     16'h0032
`define DSA_CORE_WPAG     16'h0034

// Reset values and status fields
`define DSA_PAG_RESET     16'h0000
`define DSA_ST_RD_ERR     0
`define DSA_ST_WR_ERR     1

`endif

// ===== dsa_pkg.sv
// Types of the data space access unit
package dsa_pkg;
`include "dsa_consts.svh"

  typedef enum logic [1:0] {
    DSA_MODE_IND     = 2'h0,
    DSA_MODE_POSTINC = 2'h1,
    DSA_MODE_DIR16   = 2'h3,
    DSA_MODE_DIR13   = 2'h2
  } dsa_mode_t;

  typedef enum logic [1:0] {
    DSA_WOP_NONE  = 2'h0,
    DSA_WOP_LOADB = 2'h1,
    DSA_WOP_SEXT  = 2'h3,
    DSA_WOP_UCLR  = 2'h2
  } dsa_wop_t;

  typedef enum logic [1:0] {
    DSA_RGN_SFR = 2'h0,
    DSA_RGN_RAM = 2'h1,
    DSA_RGN_WIN = 2'h3
  } dsa_rgn_t;

  typedef struct packed {
    logic [15:0]                       rd_page;
    logic [15:0]                       wr_page;
    logic [1:0]                        stat;
    logic [1:0]                        mask;
    logic [15:0]                       rd_data;
    logic                              rd_valid;
    logic                              addr_err;
    logic                              err_write;
    logic [15:0]                       wop_result;
    logic                              wop_done;
    logic                              sfr_wr_en;
    logic [15:0]                       sfr_wr_addr;
    logic [15:0]                       sfr_wr_data;
    logic [1:0]                        sfr_wr_be;
    logic                              win_wr_en;
    logic [30:0]                       win_wr_addr;
    logic [15:0]                       win_wr_data;
    logic [1:0]                        win_wr_be;
    logic                              apb_rdy;
    logic [31:0]                       prdata;
    logic                              pslverr;
    logic [`DSA_RAM_WORDS-1:0][15:0]   ram;
  } dsa_state_t;
endpackage

// ===== dsa_agu.sv
// Effective address generator for one access direction
`timescale 1ns/1ps
module dsa_agu
  import dsa_pkg::*;
(
  // Request
  input  dsa_mode_t   mode,
  input  logic [15:0] field,
  input  logic [15:0] pointer,
  input  logic        byte_op,
  // Result
  output logic [15:0] ea,
  output logic [15:0] ptr_next,
  output logic        misalign
);
`include "dsa_consts.svh"

  logic [15:0] step;

  always_comb
  begin
    step     = byte_op ? `DSA_BYTE_STEP : `DSA_WORD_STEP;
    ea       = pointer;
    ptr_next = pointer;
    case (mode)
      DSA_MODE_DIR13:   ea = field & `DSA_NEAR_MASK;
      DSA_MODE_DIR16:   ea = field;
      DSA_MODE_POSTINC: ptr_next = pointer + step;
      default:          ea = pointer;
    endcase
    misalign = !byte_op && ea[0];
  end
endmodule

// ===== dsa_top.sv
// Data space address decode, byte and word access and address error logic
`timescale 1ns/1ps
module dsa_top
  import dsa_pkg::*;
(
  // Clock and reset
  input  logic        ref_clk,
  input  logic        arst_n,
  // APB register port
  input  logic [31:0] paddr,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  output logic        irq,
  // Read address generator
  input  logic        rd_req,
  input  dsa_mode_t   rd_mode,
  input  logic [15:0] rd_field,
  input  logic [15:0] rd_ptr,
  input  logic        rd_byte,
  output logic [15:0] rd_ptr_next,
  output logic [15:0] rd_data,
  output logic        rd_valid,
  // Write address generator
  input  logic        wr_req,
  input  dsa_mode_t   wr_mode,
  input  logic [15:0] wr_field,
  input  logic [15:0] wr_ptr,
  input  logic        wr_byte,
  input  logic [15:0] wr_data,
  output logic [15:0] wr_ptr_next,
  // Address error to exception logic
  output logic        addr_err,
  output logic        addr_err_write,
  // Peripheral register side
  output logic [15:0] sfr_rd_addr,
  input  logic        sfr_rd_hit,
  input  logic [15:0] sfr_rd_data,
  output logic        sfr_wr_en,
  output logic [15:0] sfr_wr_addr,
  output logic [15:0] sfr_wr_data,
  output logic [1:0]  sfr_wr_be,
  // Extended data window side
  output logic [30:0] win_rd_addr,
  input  logic [15:0] win_rd_data,
  output logic        win_wr_en,
  output logic [30:0] win_wr_addr,
  output logic [15:0] win_wr_data,
  output logic [1:0]  win_wr_be,
  // Working register byte operations
  input  logic        wop_req,
  input  dsa_wop_t    wop_code,
  input  logic [15:0] wop_reg,
  input  logic [7:0]  wop_byte,
  output logic [15:0] wop_result,
  output logic        wop_done
);
`include "dsa_consts.svh"

  dsa_state_t  st;
  dsa_state_t  next_st;

  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic        rd_mis;
  logic        wr_mis;
  logic [13:0] rd_idx;
  logic [13:0] wr_idx;
  logic [15:0] rd_word;
  logic [15:0] wr_lane;
  logic [1:0]  wr_be;
  logic [1:0]  err_ev;
  logic [1:0]  stat_clr;
  logic        apb_acc;
  logic        apb_hit;
  logic [7:0]  apb_idx;
  logic [31:0] apb_rd;

  //----------------------------------------------------------------------------
  // Address generators
  //----------------------------------------------------------------------------
  dsa_agu u_rd_agu (
    .mode     (rd_mode),
    .field    (rd_field),
    .pointer  (rd_ptr),
    .byte_op  (rd_byte),
    .ea       (rd_ea),
    .ptr_next (rd_ptr_next),
    .misalign (rd_mis)
  );

  dsa_agu u_wr_agu (
    .mode     (wr_mode),
    .field    (wr_field),
    .pointer  (wr_ptr),
    .byte_op  (wr_byte),
    .ea       (wr_ea),
    .ptr_next (wr_ptr_next),
    .misalign (wr_mis)
  );

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  function automatic dsa_rgn_t dsa_region(input logic [15:0] a);
    if (a[15])
      dsa_region = DSA_RGN_WIN;
    else if (a < `DSA_RAM_BASE)
      dsa_region = DSA_RGN_SFR;
    else
      dsa_region = DSA_RGN_RAM;
  endfunction

  function automatic logic [15:0] dsa_merge(input logic [15:0] old, input logic [15:0] val,
                                            input logic [1:0] be);
    dsa_merge = {be[1] ? val[15:8] : old[15:8], be[0] ? val[7:0] : old[7:0]};
  endfunction

  //----------------------------------------------------------------------------
  // Decode
  //----------------------------------------------------------------------------
  assign rd_idx      = rd_ea[14:1] - `DSA_RAM_WORD_OFS;
  assign wr_idx      = wr_ea[14:1] - `DSA_RAM_WORD_OFS;
  assign sfr_rd_addr = {rd_ea[15:1], 1'b0};
  assign win_rd_addr = {st.rd_page, rd_ea[14:1], 1'b0};
  assign err_ev      = {wr_req && wr_mis, rd_req && rd_mis};
  assign apb_acc     = psel && penable;
  assign apb_idx     = paddr[9:2];
  assign apb_hit     = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0) &&
                       (apb_idx == `DSA_IDX_RPAG || apb_idx == `DSA_IDX_WPAG ||
                        apb_idx == `DSA_IDX_STAT || apb_idx == `DSA_IDX_MASK);

  always_comb
  begin
    wr_lane = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
    wr_be   = wr_byte ? (wr_ea[0] ? 2'h2 : 2'h1) : 2'h3;
  end

  always_comb
  begin
    rd_word = 16'h0000;
    case (dsa_region(rd_ea))
      DSA_RGN_RAM: rd_word = st.ram[rd_idx];
      DSA_RGN_WIN: rd_word = win_rd_data;
      default:
      begin
        if (sfr_rd_addr == `DSA_CORE_RPAG)
          rd_word = st.rd_page;
        else if (sfr_rd_addr == `DSA_CORE_WPAG)
          rd_word = st.wr_page;
        else
          rd_word = sfr_rd_hit ? sfr_rd_data : 16'h0000;
      end
    endcase
  end

  always_comb
  begin
    apb_rd = 32'h00000000;
    case (apb_idx)
      `DSA_IDX_RPAG: apb_rd = {16'h0000, st.rd_page};
      `DSA_IDX_WPAG: apb_rd = {16'h0000, st.wr_page};
      `DSA_IDX_STAT: apb_rd = {30'h00000000, st.stat};
      `DSA_IDX_MASK: apb_rd = {30'h00000000, st.mask};
      default:       apb_rd = 32'h00000000;
    endcase
    if (!apb_hit)
      apb_rd = 32'h00000000;
  end

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb
  begin
    next_st           = st;
    next_st.rd_valid  = 1'b0;
    next_st.wop_done  = 1'b0;
    next_st.sfr_wr_en = 1'b0;
    next_st.win_wr_en = 1'b0;
    stat_clr          = 2'b00;

    // Read access, completes even when misaligned
    if (rd_req)
    begin
      next_st.rd_valid = 1'b1;
      if (rd_byte)
        next_st.rd_data = {8'h00, rd_ea[0] ? rd_word[15:8] : rd_word[7:0]};
      else
        next_st.rd_data = rd_word;
    end

    // Write access, suppressed when misaligned
    if (wr_req && !wr_mis)
    begin
      case (dsa_region(wr_ea))
        DSA_RGN_RAM:
          next_st.ram[wr_idx] = dsa_merge(st.ram[wr_idx], wr_lane, wr_be);
        DSA_RGN_WIN:
        begin
          next_st.win_wr_en   = 1'b1;
          next_st.win_wr_addr = {st.wr_page, wr_ea[14:1], 1'b0};
          next_st.win_wr_data = wr_lane;
          next_st.win_wr_be   = wr_be;
        end
        default:
        begin
          if ({wr_ea[15:1], 1'b0} == `DSA_CORE_RPAG)
            next_st.rd_page = dsa_merge(st.rd_page, wr_lane, wr_be);
          else if ({wr_ea[15:1], 1'b0} == `DSA_CORE_WPAG)
            next_st.wr_page = dsa_merge(st.wr_page, wr_lane, wr_be);
          else
          begin
            next_st.sfr_wr_en   = 1'b1;
            next_st.sfr_wr_addr = {wr_ea[15:1], 1'b0};
            next_st.sfr_wr_data = wr_lane;
            next_st.sfr_wr_be   = wr_be;
          end
        end
      endcase
    end

    // Address error, one cycle after the offending access
    next_st.addr_err  = |err_ev;
    next_st.err_write = err_ev[`DSA_ST_WR_ERR];

    // Working register byte operations
    if (wop_req)
    begin
      next_st.wop_done = 1'b1;
      case (wop_code)
        DSA_WOP_LOADB: next_st.wop_result = {wop_reg[15:8], wop_byte};
        DSA_WOP_SEXT:  next_st.wop_result = {{8{wop_reg[7]}}, wop_reg[7:0]};
        DSA_WOP_UCLR:  next_st.wop_result = {8'h00, wop_reg[7:0]};
        default:       next_st.wop_result = wop_reg;
      endcase
    end

    // APB slave with one wait state
    if (apb_acc && !st.apb_rdy)
    begin
      next_st.apb_rdy = 1'b1;
      next_st.prdata  = apb_rd;
      next_st.pslverr = !apb_hit;
    end
    else
    begin
      next_st.apb_rdy = 1'b0;
      next_st.pslverr = 1'b0;
    end
    if (apb_acc && st.apb_rdy && pwrite && apb_hit)
    begin
      case (apb_idx)
        `DSA_IDX_RPAG: next_st.rd_page = pwdata[15:0];
        `DSA_IDX_WPAG: next_st.wr_page = pwdata[15:0];
        `DSA_IDX_STAT: stat_clr = pwdata[1:0];
        `DSA_IDX_MASK: next_st.mask = pwdata[1:0];
        default:       stat_clr = 2'b00;
      endcase
    end

    // Sticky status, a new event wins over a clear
    next_st.stat = (st.stat & ~stat_clr) | err_ev;
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st         <= '0;
      st.rd_page <= `DSA_PAG_RESET;
      st.wr_page <= `DSA_PAG_RESET;
    end
    else
      st <= next_st;
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign prdata         = st.prdata;
  assign pready         = st.apb_rdy;
  assign pslverr        = st.pslverr;
  assign irq            = |(st.stat & st.mask);
  assign rd_data        = st.rd_data;
  assign rd_valid       = st.rd_valid;
  assign addr_err       = st.addr_err;
  assign addr_err_write = st.err_write;
  assign sfr_wr_en      = st.sfr_wr_en;
  assign sfr_wr_addr    = st.sfr_wr_addr;
  assign sfr_wr_data    = st.sfr_wr_data;
  assign sfr_wr_be      = st.sfr_wr_be;
  assign win_wr_en      = st.win_wr_en;
  assign win_wr_addr    = st.win_wr_addr;
  assign win_wr_data    = st.win_wr_data;
  assign win_wr_be      = st.win_wr_be;
  assign wop_result     = st.wop_result;
  assign wop_done       = st.wop_done;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_word_rd_odd;
    rd_req && !rd_byte && rd_ea[0];
  endsequence

  sequence s_word_wr_odd;
    wr_req && !wr_byte && wr_ea[0];
  endsequence

  sequence s_byte_sfr_wr;
    wr_req && wr_byte && !wr_ea[15] && (wr_ea < `DSA_RAM_BASE) &&
    ({wr_ea[15:1], 1'b0} != `DSA_CORE_RPAG) && ({wr_ea[15:1], 1'b0} != `DSA_CORE_WPAG);
  endsequence

  a_err_raise: assert property (s_word_rd_odd or s_word_wr_odd |=> addr_err)
    else $error("misaligned word access gave no address error");

  a_err_single: assert property (addr_err |-> $past(rd_req && rd_mis) || $past(wr_req && wr_mis))
    else $error("address error without a misaligned access");

  a_wr_suppress: assert property (s_word_wr_odd |=> !sfr_wr_en && !win_wr_en &&
                                  addr_err && addr_err_write)
    else $error("misaligned write reached a target");

  a_rd_complete: assert property (s_word_rd_odd |=> rd_valid && addr_err)
    else $error("misaligned read did not complete");

  a_byte_lane: assert property (rd_req && rd_byte |=> rd_valid && rd_data[15:8] == 8'h00)
    else $error("byte read left data on the high lane");

  a_byte_strobe: assert property (s_byte_sfr_wr |=> sfr_wr_en && sfr_wr_be == ($past(wr_ea[0]) ? 2'h2 : 2'h1))
    else $error("byte write strobe on the wrong half");

  a_win_paging: assert property (wr_req && !wr_mis && wr_ea[15] |=>
                                 win_wr_en && win_wr_addr == {$past(st.wr_page), $past(wr_ea[14:1]), 1'b0})
    else $error("window write not paged");

  a_sfr_zero: assert property (rd_req && !rd_byte && !rd_ea[15] && rd_ea < `DSA_RAM_BASE && !sfr_rd_hit &&
                               sfr_rd_addr != `DSA_CORE_RPAG && sfr_rd_addr != `DSA_CORE_WPAG
                               |=> rd_data == 16'h0000)
    else $error("unimplemented register did not read zero");

  a_postinc_step: assert property (rd_mode == DSA_MODE_POSTINC |-> rd_ptr_next - rd_ptr ==
                                   (rd_byte ? `DSA_BYTE_STEP : `DSA_WORD_STEP))
    else $error("post increment step wrong");

  a_near_direct: assert property (wr_mode == DSA_MODE_DIR13 |-> wr_ea[15:13] == 3'h0 && wr_ea[12:0] == wr_field[12:0])
    else $error("near direct address out of range");

  a_sign_ext: assert property (wop_req && wop_code == DSA_WOP_SEXT |=>
                               wop_done && wop_result == {{8{$past(wop_reg[7])}}, $past(wop_reg[7:0])})
    else $error("sign extend result wrong");

  a_load_byte: assert property (wop_req && wop_code == DSA_WOP_LOADB |=>
                                wop_result[15:8] == $past(wop_reg[15:8]) && wop_result[7:0] == $past(wop_byte))
    else $error("byte load touched the high byte");

endmodule

// ===== dsa_far_mdl.sv
// Model of the peripheral registers and extended window facing the block
`timescale 1ns/1ps
module dsa_far_mdl
  import dsa_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // Register side
  input  wire logic [15:0] sfr_rd_addr,
  output logic             sfr_rd_hit,
  output logic [15:0]      sfr_rd_data,
  // Window side
  input  wire logic [30:0] win_rd_addr,
  output logic [15:0]      win_rd_data
);
  logic [15:0] churn;

  initial churn = 16'h0000;
  // Garbage that moves every cycle when no register answers
  always @(posedge ref_clk) churn <= churn + 16'h9E37;
  // Registers implemented only in the 0100h block
  assign sfr_rd_hit  = (sfr_rd_addr[15:8] == 8'h01);
  assign sfr_rd_data = sfr_rd_hit ? ~sfr_rd_addr : churn;
  assign win_rd_data = win_rd_addr[15:0] ^ 16'h5A5A;
endmodule

// ===== tb.sv
// Self-checking testbench of the data space access unit
`timescale 1ns/1ps
module tb
  import dsa_pkg::*;
;
  // ----------------
  // Signals
  // ----------------
  logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic        rd_req, rd_byte, rd_valid, wr_req, wr_byte, addr_err, addr_err_write, rerr;
  dsa_mode_t   rd_mode, wr_mode, cmode;
  logic [15:0] rd_field, rd_ptr, rd_ptr_next, rd_data, wr_field, wr_ptr, wr_data, wr_ptr_next;
  logic [15:0] sfr_rd_addr, sfr_rd_data, sfr_wr_addr, sfr_wr_data, win_rd_data, win_wr_data;
  logic        sfr_rd_hit, sfr_wr_en, win_wr_en, wop_req, wop_done;
  logic [1:0]  sfr_wr_be, win_wr_be;
  logic [30:0] win_rd_addr, win_wr_addr;
  dsa_wop_t    wop_code;
  logic [15:0] wop_reg, wop_result;
  logic [7:0]  wop_byte;
  int          failures, num_checks;

  dsa_top u_dut (
    .ref_clk, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
    .rd_req, .rd_mode, .rd_field, .rd_ptr, .rd_byte, .rd_ptr_next, .rd_data, .rd_valid,
    .wr_req, .wr_mode, .wr_field, .wr_ptr, .wr_byte, .wr_data, .wr_ptr_next, .addr_err, .addr_err_write,
    .sfr_rd_addr, .sfr_rd_hit, .sfr_rd_data, .sfr_wr_en, .sfr_wr_addr, .sfr_wr_data, .sfr_wr_be,
    .win_rd_addr, .win_rd_data, .win_wr_en, .win_wr_addr, .win_wr_data, .win_wr_be,
    .wop_req, .wop_code, .wop_reg, .wop_byte, .wop_result, .wop_done
  );

  dsa_far_mdl u_far (
    .ref_clk, .sfr_rd_addr, .sfr_rd_hit, .sfr_rd_data, .win_rd_addr, .win_rd_data
  );

  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
      @(posedge ref_clk);
    while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic core(input logic dr, input logic dw, input logic [15:0] fld, input logic byt,
                      input logic [15:0] wd);
    @(posedge ref_clk);
    rd_req <= dr;
    wr_req <= dw;
    rd_mode <= cmode;
    wr_mode <= cmode;
    rd_field <= fld;
    wr_field <= fld;
    rd_ptr <= fld;
    wr_ptr <= fld;
    rd_byte <= byt;
    wr_byte <= byt;
    wr_data <= wd;
    @(posedge ref_clk);
    rd_req <= 1'h0;
    wr_req <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [15:0] fld, input logic byt);
    core(1'h1, 1'h0, fld, byt, 16'h0000);
  endtask

  task automatic wr(input logic [15:0] fld, input logic byt, input logic [15:0] wd);
    core(1'h0, 1'h1, fld, byt, wd);
  endtask

  task automatic wop(input dsa_wop_t cd, input logic [15:0] rg, input logic [7:0] b, input logic [15:0] exp);
    @(posedge ref_clk);
    wop_req <= 1'h1;
    wop_code <= cd;
    wop_reg <= rg;
    wop_byte <= b;
    @(posedge ref_clk);
    wop_req <= 1'h0;
    #1;
    chk("wop_result", wop_result, exp);
    chk("wop_done", wop_done, 1'h1);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs;
    apb(1'h0, 32'h000000C8, 32'h0);
    chk("rpag reset", rdat, 32'h0);
    apb(1'h0, 32'h000000D0, 32'h0);
    chk("wpag reset", rdat, 32'h0);
    apb(1'h0, 32'h00000010, 32'h0);
    chk("unmapped err", rerr, 1'h1);
    apb(1'h1, 32'h000000C8, 32'hFFFF0003);
    apb(1'h0, 32'h000000C8, 32'h0);
    chk("rpag", rdat, 32'h00000003);
  endtask

  task automatic t_ram;
    wr(16'h0800, 1'h0, 16'hA55A);
    rd(16'h0800, 1'h0);
    chk("ram word", rd_data, 16'hA55A);
    chk("rd_valid", rd_valid, 1'h1);
    rd(16'h0801, 1'h0 + 1'h1);
    chk("odd byte", rd_data, 16'h00A5);
    wr(16'h7FFE, 1'h0, 16'h7777);
    rd(16'h7FFE, 1'h0);
    chk("ram top", rd_data, 16'h7777);
    wr(16'h0802, 1'h0, 16'h1111);
    wr(16'h0803, 1'h1, 16'h003C);
    rd(16'h0802, 1'h0);
    chk("byte lane hi", rd_data, 16'h3C11);
    wr(16'h0802, 1'h1, 16'h0099);
    rd(16'h0802, 1'h0);
    chk("byte lane lo", rd_data, 16'h3C99);
  endtask

  task automatic t_misalign;
    wr(16'h0804, 1'h0, 16'h2222);
    chk("no err", addr_err, 1'h0);
    wr(16'h0805, 1'h0, 16'hBEEF);
    chk("wr err", addr_err, 1'h1);
    chk("wr err side", addr_err_write, 1'h1);
    @(posedge ref_clk);
    #1;
    chk("err pulse", addr_err, 1'h0);
    rd(16'h0805, 1'h0);
    chk("rd err", addr_err, 1'h1);
    chk("rd err side", addr_err_write, 1'h0);
    chk("rd completes", rd_data, 16'h2222);
    rd(16'h0805, 1'h1);
    chk("byte no err", addr_err, 1'h0);
    chk("byte hi", rd_data, 16'h0022);
    apb(1'h0, 32'h000000E0, 32'h0);
    chk("status", rdat, 32'h3);
    chk("irq masked", irq, 1'h0);
    apb(1'h1, 32'h000000E8, 32'h1);
    apb(1'h0, 32'h000000E0, 32'h0);
    chk("irq", irq, 1'h1);
    apb(1'h1, 32'h000000E0, 32'h1);
    apb(1'h0, 32'h000000E0, 32'h0);
    chk("status clr", rdat, 32'h2);
    chk("irq clr", irq, 1'h0);
  endtask

  task automatic t_modes;
    cmode = DSA_MODE_DIR13;
    rd(16'hE804, 1'h0);
    chk("near field", rd_data, 16'h2222);
    cmode = DSA_MODE_IND;
    rd(16'h0804, 1'h0);
    chk("indirect", rd_data, 16'h2222);
    cmode = DSA_MODE_POSTINC;
    rd(16'h0810, 1'h1);
    @(posedge ref_clk);
    wr_byte <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk("inc byte", rd_ptr_next, 16'h0811);
    chk("inc word", wr_ptr_next, 16'h0812);
    @(posedge ref_clk);
    rd_mode <= DSA_MODE_IND;
    @(posedge ref_clk);
    #1;
    chk("no inc", rd_ptr_next, 16'h0810);
    cmode = DSA_MODE_DIR16;
  endtask

  task automatic t_sfr;
    rd(16'h0104, 1'h0);
    chk("sfr word", rd_data, 16'hFEFB);
    chk("sfr addr", sfr_rd_addr, 16'h0104);
    rd(16'h0105, 1'h1);
    chk("sfr byte", rd_data, 16'h00FE);
    rd(16'h0204, 1'h0);
    chk("sfr hole", rd_data, 16'h0000);
    rd(16'h07FE, 1'h0);
    chk("sfr top hole", rd_data, 16'h0000);
    wr(16'h0106, 1'h0, 16'h1357);
    chk("sfr wr_en", sfr_wr_en, 1'h1);
    chk("sfr wr addr", sfr_wr_addr, 16'h0106);
    chk("sfr wr data", sfr_wr_data, 16'h1357);
    chk("sfr be word", sfr_wr_be, 2'h3);
    wr(16'h0107, 1'h1, 16'h005A);
    chk("sfr be hi", sfr_wr_be, 2'h2);
    chk("sfr dup", sfr_wr_data, 16'h5A5A);
    chk("win idle", win_wr_en, 1'h0);
  endtask

  task automatic t_eds;
    apb(1'h1, 32'h000000D0, 32'h5);
    wr(16'h8006, 1'h0, 16'h2468);
    chk("win wr_en", win_wr_en, 1'h1);
    chk("win wr addr", win_wr_addr, {16'h0005, 15'h0006});
    chk("win wr data", win_wr_data, 16'h2468);
    chk("win wr be", win_wr_be, 2'h3);
    chk("sfr idle", sfr_wr_en, 1'h0);
    rd(16'h9000, 1'h0);
    chk("win rd addr", win_rd_addr, {16'h0003, 15'h1000});
    chk("win rd data", rd_data, 16'hCA5A);
    rd(16'h0034, 1'h0);
    chk("core wpag", rd_data, 16'h0005);
    wr(16'h0035, 1'h1, 16'h0012);
    rd(16'h0034, 1'h0);
    chk("core wpag hi", rd_data, 16'h1205);
  endtask

  task automatic t_both;
    wr(16'h0806, 1'h0, 16'h4444);
    core(1'h1, 1'h1, 16'h0806, 1'h0, 16'h5555);
    chk("old data", rd_data, 16'h4444);
    rd(16'h0806, 1'h0);
    chk("new data", rd_data, 16'h5555);
  endtask

  initial
  begin
    #100000;
    failures++;
    summarize();
  end

  initial
  begin
    failures = 0;
    num_checks = 0;
    cmode = DSA_MODE_DIR16;
    arst_n = 1'h0;
    {psel, penable, pwrite, rd_req, rd_byte, wr_req, wr_byte, wop_req} = 8'h00;
    {paddr, pwdata} = 64'h0;
    {rd_field, rd_ptr, wr_field, wr_ptr, wr_data, wop_reg} = 96'h0;
    rd_mode = DSA_MODE_IND;
    wr_mode = DSA_MODE_IND;
    wop_code = DSA_WOP_NONE;
    wop_byte = 8'h00;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'h1;
    t_regs();
    t_ram();
    t_misalign();
    t_modes();
    t_sfr();
    t_eds();
    t_both();
    wop(DSA_WOP_LOADB, 16'h1234, 8'hAB, 16'h12AB);
    wop(DSA_WOP_SEXT, 16'h0080, 8'h80, 16'hFF80);
    wop(DSA_WOP_SEXT, 16'h127F, 8'h7F, 16'h007F);
    wop(DSA_WOP_UCLR, 16'hABCD, 8'hCD, 16'h00CD);
    summarize();
  end
endmodule
